// File: acc_alu_regs.vh
// register map, field layout, opcodes and timing counts of the accumulator alu
`ifndef ACC_ALU_REGS_VH
`define ACC_ALU_REGS_VH

`define WORD_W 24
`define ADDR_W 3

// register word addresses
`define REG_ACC_X 3'h0
`define REG_ACC_Y 3'h1
`define REG_ACC_Z 3'h2
`define REG_ACC_R 3'h3
`define REG_CMD 3'h4
`define REG_IMM 3'h5
`define REG_FLAGS 3'h6

// command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DST_LSB 3
`define CMD_DST_MSB 4
`define CMD_SRC_LSB 5
`define CMD_SRC_MSB 6
`define CMD_IMM_BIT 7
`define CMD_IDX_LSB 8
`define CMD_IDX_MSB 12

// flag register bits
`define FLG_CARRY 0
`define FLG_OVF 1
`define FLG_SIGN 2
`define FLG_ZERO 3
`define STAT_BUSY 4

// operand selectors
`define SEL_X 2'h0
`define SEL_Y 2'h1
`define SEL_Z 2'h2
`define SEL_R 2'h3

// opcodes
`define OP_ABS 3'h0
`define OP_ADD 3'h1
`define OP_AND 3'h2
`define OP_BCLR 3'h3
`define OP_BINV 3'h4
`define OP_BSET 3'h5

// instruction cycle counts
`define CYC_ABS 3'h2
`define CYC_ADD_ACC 3'h2
`define CYC_ADD_IMM 3'h4
`define CYC_AND_ACC 3'h3
`define CYC_AND_IMM 3'h6
`define CYC_BIT 3'h2

`define BIT_IDX_MAX 5'h17

// reset values
`define RST_WORD 24'h000000
`define RST_FLAGS 4'h0

`endif

// File: acc_alu.v
// 24-bit accumulator alu: abs, add, and, single-bit clear/invert/set
// Summary of operation
// RL1 - 24-bit two's-complement datapath throughout
// RL2 - result written to first operand only
// RL3 - ram window word acts as accumulator
// RL4 - four flags track the last operation
// RL5 - abs gives magnitude, all flags, 2 cycles
// RL6 - add accumulator or immediate, all flags
// RL7 - and updates sign and zero only
// RL8 - bit clear by index 0 to 23
// RL9 - bit invert by index 0 to 23
// RL10 - bit set by index 0 to 23
// RL11 - any of four accumulators as destination
// RL12 - carry takes carry-out of addition
// RL13 - overflow flags signed overflow
// RL14 - sign follows msb of written result
// RL15 - sign/zero ops keep carry and overflow
// RL16 - results and flags commit at final cycle
`timescale 1ns/100ps
`default_nettype none
`include "acc_alu_regs.vh"

module acc_alu #(
    parameter WIDTH = 24
) (
    input wire mclk,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [WIDTH-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [WIDTH-1:0] rdata,
    input wire [WIDTH-1:0] ram_rdata,
    output reg [WIDTH-1:0] ram_wdata,
    output reg ram_we,
    output wire busy,
    output reg done,
    output wire carry_flag,
    output wire ovf_flag,
    output wire sign_flag,
    output wire zero_flag
);

    reg [WIDTH-1:0] acc_x_q;
    reg [WIDTH-1:0] acc_y_q;
    reg [WIDTH-1:0] acc_z_q;
    reg [WIDTH-1:0] imm_q;
    reg [3:0] flags_q;
    reg busy_q;
    reg [2:0] cnt_q;
    reg [2:0] op_q;
    reg [1:0] dst_q;
    reg [1:0] src_q;
    reg use_imm_q;
    reg [4:0] idx_q;

    wire [2:0] cmd_op = wdata[`CMD_OP_MSB:`CMD_OP_LSB];
    wire cmd_imm = wdata[`CMD_IMM_BIT];
    wire [4:0] cmd_idx = wdata[`CMD_IDX_MSB:`CMD_IDX_LSB];
    wire cmd_wr = wr && (addr == `REG_CMD);

    // operand fetch, the ram window reads like any accumulator
    function [WIDTH-1:0] pick;
        input [1:0] sel;
        input [WIDTH-1:0] x;
        input [WIDTH-1:0] y;
        input [WIDTH-1:0] z;
        input [WIDTH-1:0] r;
        begin
            case (sel)
                `SEL_X: pick = x;
                `SEL_Y: pick = y;
                `SEL_Z: pick = z;
                default: pick = r; // RL3
            endcase
        end
    endfunction

    wire [WIDTH-1:0] opa = pick(dst_q, acc_x_q, acc_y_q, acc_z_q, ram_rdata);
    wire [WIDTH-1:0] opb_acc =
        pick(src_q, acc_x_q, acc_y_q, acc_z_q, ram_rdata);
    wire [WIDTH-1:0] opb = use_imm_q ? imm_q : opb_acc;

    // command acceptance: unknown opcodes and bit indices above 23 are dropped
    reg [2:0] cyc;
    reg cmd_ok;
    always @* begin
        cyc = `CYC_BIT;
        cmd_ok = 1'b1;
        case (cmd_op)
            `OP_ABS: cyc = `CYC_ABS; // RL5
            `OP_ADD: cyc = cmd_imm ? `CYC_ADD_IMM : `CYC_ADD_ACC; // RL6
            `OP_AND: cyc = cmd_imm ? `CYC_AND_IMM : `CYC_AND_ACC; // RL7
            `OP_BCLR, `OP_BINV, `OP_BSET: begin
                cyc = `CYC_BIT;
                cmd_ok = (cmd_idx <= `BIT_IDX_MAX);
            end
            default: cmd_ok = 1'b0;
        endcase
    end

    // result and flag computation
    wire [WIDTH:0] sum = {1'b0, opa} + {1'b0, opb};
    wire [WIDTH-1:0] neg = (~opa) + {{(WIDTH-1){1'b0}}, 1'b1};
    wire [WIDTH-1:0] mask = {{(WIDTH-1){1'b0}}, 1'b1} << idx_q;
    reg [WIDTH-1:0] res;
    reg new_c;
    reg new_o;
    reg full_set;
    always @* begin
        res = opa;
        new_c = flags_q[`FLG_CARRY];
        new_o = flags_q[`FLG_OVF];
        full_set = 1'b0;
        case (op_q)
            `OP_ABS: begin
                // most negative value has no positive twin: result wraps
                res = opa[WIDTH-1] ? neg : opa; // RL5 RL1
                new_c = 1'b0;
                new_o = opa[WIDTH-1] & neg[WIDTH-1]; // RL13
                full_set = 1'b1;
            end
            `OP_ADD: begin
                res = sum[WIDTH-1:0]; // RL6 RL1
                new_c = sum[WIDTH]; // RL12
                new_o = (opa[WIDTH-1] == opb[WIDTH-1]) &&
                        (sum[WIDTH-1] != opa[WIDTH-1]); // RL13
                full_set = 1'b1;
            end
            `OP_AND: res = opa & opb; // RL7
            `OP_BCLR: res = opa & ~mask; // RL8
            `OP_BINV: res = opa ^ mask; // RL9
            `OP_BSET: res = opa | mask; // RL10
            default: res = opa;
        endcase
        if (!full_set) begin
            new_c = flags_q[`FLG_CARRY]; // RL15
            new_o = flags_q[`FLG_OVF]; // RL15
        end
    end

    wire commit = busy_q && (cnt_q == 3'h0);

    // sequencer: one instruction in flight, commands while busy are ignored
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
            op_q <= `OP_ABS;
            dst_q <= `SEL_X;
            src_q <= `SEL_X;
            use_imm_q <= 1'b0;
            idx_q <= 5'h00;
            done <= 1'b0;
        end else begin
            done <= commit;
            if (busy_q) begin
                if (commit) begin
                    busy_q <= 1'b0; // RL16
                end else begin
                    cnt_q <= cnt_q - 3'h1;
                end
            end else if (cmd_wr && cmd_ok) begin
                busy_q <= 1'b1;
                cnt_q <= cyc - 3'h1;
                op_q <= cmd_op;
                dst_q <= wdata[`CMD_DST_MSB:`CMD_DST_LSB]; // RL11
                src_q <= wdata[`CMD_SRC_MSB:`CMD_SRC_LSB];
                use_imm_q <= cmd_imm;
                idx_q <= cmd_idx;
            end
        end
    end

    // accumulators, immediate and flags
    wire bus_wr_ok = wr && !busy_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_x_q <= `RST_WORD;
            acc_y_q <= `RST_WORD;
            acc_z_q <= `RST_WORD;
            imm_q <= `RST_WORD;
            flags_q <= `RST_FLAGS;
            ram_wdata <= `RST_WORD;
            ram_we <= 1'b0;
        end else begin
            ram_we <= 1'b0;
            if (commit) begin
                // only the destination changes, source stays intact
                case (dst_q) // RL2 RL11
                    `SEL_X: acc_x_q <= res;
                    `SEL_Y: acc_y_q <= res;
                    `SEL_Z: acc_z_q <= res;
                    default: begin
                        ram_wdata <= res; // RL3
                        ram_we <= 1'b1;
                    end
                endcase
                flags_q[`FLG_CARRY] <= new_c; // RL4 RL16
                flags_q[`FLG_OVF] <= new_o; // RL4
                flags_q[`FLG_SIGN] <= res[WIDTH-1]; // RL14
                flags_q[`FLG_ZERO] <= (res == `RST_WORD); // RL4
            end else if (bus_wr_ok) begin
                // plain loads by software leave the flags alone
                case (addr)
                    `REG_ACC_X: acc_x_q <= wdata;
                    `REG_ACC_Y: acc_y_q <= wdata;
                    `REG_ACC_Z: acc_z_q <= wdata;
                    `REG_ACC_R: begin
                        ram_wdata <= wdata;
                        ram_we <= 1'b1;
                    end
                    `REG_IMM: imm_q <= wdata;
                    default: ;
                endcase
            end
        end
    end

    // read port, data one cycle after the strobe
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `RST_WORD;
        end else if (rd) begin
            case (addr)
                `REG_ACC_X: rdata <= acc_x_q;
                `REG_ACC_Y: rdata <= acc_y_q;
                `REG_ACC_Z: rdata <= acc_z_q;
                `REG_ACC_R: rdata <= ram_rdata;
                `REG_IMM: rdata <= imm_q;
                `REG_FLAGS: rdata <= {{(WIDTH-5){1'b0}}, busy_q, flags_q};
                default: rdata <= `RST_WORD;
            endcase
        end else begin
            rdata <= `RST_WORD;
        end
    end

    assign busy = busy_q;
    assign carry_flag = flags_q[`FLG_CARRY];
    assign ovf_flag = flags_q[`FLG_OVF];
    assign sign_flag = flags_q[`FLG_SIGN];
    assign zero_flag = flags_q[`FLG_ZERO];

endmodule
`default_nettype wire

// File: ram_word_model.sv
// data ram word seen through the address pointer
`timescale 1ns/100ps
`default_nettype none
module ram_word_model (
    input wire logic mclk,
    input wire logic ram_we,
    input wire logic [23:0] ram_wdata,
    output logic [23:0] ram_rdata
);
    // ram is not reset, so it starts at a non-zero word
    initial ram_rdata = 24'hffffff;
    always @(posedge mclk) begin
        if (ram_we) begin
            ram_rdata <= ram_wdata;
        end
    end
endmodule
`default_nettype wire

// File: acc_alu_checker.sv
// port checker of the accumulator alu
`timescale 1ns/100ps
`default_nettype none
module acc_alu_checker #(
    parameter WIDTH = 24
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [WIDTH-1:0] rdata,
    input wire logic [WIDTH-1:0] ram_rdata,
    input wire logic [WIDTH-1:0] ram_wdata,
    input wire logic ram_we,
    input wire logic busy,
    input wire logic done,
    input wire logic carry_flag,
    input wire logic ovf_flag,
    input wire logic sign_flag,
    input wire logic zero_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire [3:0] flg = {zero_flag, sign_flag, ovf_flag, carry_flag};
    flag_commit_a: assert property ($changed(flg) |-> done)
        else $error("flags moved outside a commit");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    busy_done_a: assert property ($fell(busy) |-> done)
        else $error("busy ended without done");
    busy_cause_a: assert property ($rose(busy) |->
        $past(wr) && $past(addr) == 3'h4)
        else $error("busy without a command write");
    busy_bound_a: assert property ($rose(busy) |-> ##[2:6] !busy)
        else $error("instruction too long");
    // software loads of the ram window pulse the write strobe as well
    ram_write_a: assert property (ram_we |-> done ||
        ($past(wr) && !$past(busy) && $past(addr) == 3'h3))
        else $error("ram write outside a commit or load");
    flag_read_a: assert property (rd && addr == 3'h6 |=>
        rdata == {19'h0, $past(busy), $past(flg)})
        else $error("flag word read wrong");
    ram_read_a: assert property (rd && addr == 3'h3 |=>
        rdata == $past(ram_rdata))
        else $error("ram window read wrong");
    zero_sign_a: assert property (zero_flag |-> !sign_flag)
        else $error("zero result with sign set");
    cover property (done && ram_we);
    cover property ($fell(busy));
    cover property (rd && addr == 3'h6);
endmodule
`default_nettype wire

// File: acc_alu_tb.sv
// self-checking bench of the accumulator alu
`timescale 1ns/100ps
`default_nettype none
module acc_alu_tb;
    logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [23:0] wdata = 24'h0;
    wire [23:0] rdata, ram_rdata, ram_wdata;
    wire ram_we, busy, done, carry_flag, ovf_flag, sign_flag, zero_flag;
    integer failures = 0, checks = 0;
    acc_alu DUT (
        .mclk(mclk),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .ram_rdata(ram_rdata),
        .ram_wdata(ram_wdata),
        .ram_we(ram_we),
        .busy(busy),
        .done(done),
        .carry_flag(carry_flag),
        .ovf_flag(ovf_flag),
        .sign_flag(sign_flag),
        .zero_flag(zero_flag)
    );
    ram_word_model ram (
        .mclk(mclk),
        .ram_we(ram_we),
        .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata)
    );
    initial forever #2.5 mclk = ~mclk;
    task check(input logic [23:0] seen, input logic [23:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [2:0] a, input logic [23:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [2:0] a, input logic [23:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // cmd is {idx, imm, src, dst, op}; flags are {busy, z, s, o, c}
    task exec(input logic [12:0] cmd, input logic [7:0] cyc,
        input logic [23:0] res, input logic [4:0] flg);
        integer n;
        logic [4:0] pins;
        n = 0;
        wr_reg(3'h4, {11'h0, cmd});
        do begin
            @(posedge mclk);
            #1 n = n + 1;
        end while (done !== 1'b1 && n < 20);
        check(24'(n), {16'h0, cyc});
        rd_reg({1'b0, cmd[4:3]}, res);
        rd_reg(3'h6, {19'h0, flg});
        pins = {busy, zero_flag, sign_flag, ovf_flag, carry_flag};
        check({19'h0, pins}, {19'h0, flg});
        $display("command %h done", cmd);
    endtask
    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(3'h6, 24'h0);
        wr_reg(3'h0, 24'hfffffd);
        wr_reg(3'h1, 24'h000002);
        wr_reg(3'h5, 24'h7fffff);
        wr_reg(3'h3, 24'h5a5a5a);
        rd_reg(3'h3, 24'h5a5a5a);
        wr_reg(3'h3, 24'hffffff);
        exec(13'h000, 8'h2, 24'h000003, 5'h00);
        exec(13'h021, 8'h2, 24'h000005, 5'h00);
        exec(13'h081, 8'h4, 24'h800004, 5'h06);
        exec(13'h022, 8'h3, 24'h000000, 5'h0a);
        exec(13'h1705, 8'h2, 24'h800000, 5'h06);
        exec(13'h004, 8'h2, 24'h800001, 5'h06);
        exec(13'h1703, 8'h2, 24'h000001, 5'h02);
        exec(13'h039, 8'h2, 24'h000001, 5'h01);
        exec(13'h09a, 8'h6, 24'h000001, 5'h01);
        exec(13'h515, 8'h2, 24'h000020, 5'h01);
        exec(13'h008, 8'h2, 24'h000002, 5'h00);
        // index 24 and opcode 7 are refused, so nothing may change
        wr_reg(3'h4, 24'h001805);
        wr_reg(3'h4, 24'h000007);
        repeat (8) @(posedge mclk);
        rd_reg(3'h0, 24'h000001);
        rd_reg(3'h6, 24'h0);
        $display("refusal test done");
        // loads while busy are dropped, so the immediate stays intact
        wr_reg(3'h4, 24'h000091);
        wr_reg(3'h5, 24'h000001);
        wr_reg(3'h1, 24'h123456);
        repeat (4) @(posedge mclk);
        rd_reg(3'h2, 24'h80001f);
        rd_reg(3'h1, 24'h000002);
        rd_reg(3'h6, 24'h000006);
        $display("busy drop test done");
        // reset in mid-instruction: nothing may commit afterwards
        wr_reg(3'h4, 24'h000081);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(3'h2, 24'h000000);
        rd_reg(3'h6, 24'h000000);
        $display("reset test done");
        exec(13'h1705, 8'h2, 24'h800000, 5'h04);
        summarize;
    end
    initial begin
        #20000;
        failures = failures + 1;
        summarize;
    end
endmodule
bind acc_alu acc_alu_checker #(.WIDTH(WIDTH)) chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .ram_rdata(ram_rdata),
    .ram_wdata(ram_wdata),
    .ram_we(ram_we),
    .busy(busy),
    .done(done),
    .carry_flag(carry_flag),
    .ovf_flag(ovf_flag),
    .sign_flag(sign_flag),
    .zero_flag(zero_flag)
);
`default_nettype wire
